// [logic/riu_rotate_unit.sv]
// rotate instruction unit with avalon register slave and data memory
`timescale 1ns/1ps
`include "riu_params.svh"
module riu_rotate_unit (
   input wire logic mclk,                    // 20 mhz core clock
   input wire logic rst,                     // synchronous reset, high
   input riu_pkg::riu_avs_req_t avs_req,     // avalon request group
   output riu_pkg::riu_avs_rsp_t avs_rsp     // avalon answer group
);
   import riu_pkg::*;

   // =====================================================
   // state
   localparam riu_core_t RIU_RESET = '{
      state: RIU_IDLE, w: `RIU_RST_WORK, n: 1'b0, z: 1'b0, c: 1'b0, bad: 1'b0,
      bank_select_register: `RIU_RST_BANK, ext_en: `RIU_RST_EXT, fsr2: `RIU_RST_FSR2, mem_addr: 12'h000,
      opcode: 16'h0000, eff: 12'h000, opnd: 8'h00, res: 8'h00,
      waitreq: 1'b1, ack: 1'b0, rdata: 32'h0000_0000};

   riu_core_t q_q;
   riu_core_t q_d;
   logic [7:0] mem [0:4095];
   logic mem_we;
   logic [11:0] mem_wa;
   logic [7:0] mem_wd;
   logic [11:0] calc_eff;

   // =====================================================
   // helpers
   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_rlnc(input logic [15:0] op);
      return op[15:10] == `RIU_OP_RLNC;
   endfunction

   function automatic logic is_rrc(input logic [15:0] op);
      return op[15:10] == `RIU_OP_RRC;
   endfunction

   function automatic logic [31:0] status_word(input riu_core_t s);
      logic [31:0] r;
      r = 32'h0000_0000;
      r[`RIU_ST_C] = s.c;
      r[`RIU_ST_Z] = s.z;
      r[`RIU_ST_N] = s.n;
      r[`RIU_ST_BAD] = s.bad;
      return r;
   endfunction

   riu_addr_calc u_addr (
      .f(q_q.opcode[7:0]),
      .a(q_q.opcode[`RIU_A_BIT]),
      .ext_en(q_q.ext_en),
      .bank_select_register(q_q.bank_select_register),
      .fsr2(q_q.fsr2),
      .eff(calc_eff),
      .indexed()
   );

   // =====================================================
   // next state
   always_comb begin
      logic [31:0] wv;
      wv = 32'h0000_0000;
      q_d = q_q;
      q_d.waitreq = 1'b1;
      q_d.ack = 1'b0;
      mem_we = 1'b0;
      mem_wa = q_q.eff;
      mem_wd = q_q.res;
      unique case (q_q.state)
         RIU_IDLE: begin
            // one answer per request: ack blocks a second take of the held request
            if (!q_q.ack && (avs_req.read || avs_req.write)) begin
               q_d.ack = 1'b1;
               q_d.waitreq = 1'b0;
               q_d.rdata = 32'h0000_0000;
               if (avs_req.read) begin
                  unique case (avs_req.address)
                     `RIU_REG_INSTR: q_d.rdata = {16'h0000, q_q.opcode};
                     `RIU_REG_WORK: q_d.rdata = {24'h000000, q_q.w};
                     `RIU_REG_STATUS: q_d.rdata = status_word(q_q);
                     `RIU_REG_BANK: q_d.rdata = {28'h0000000, q_q.bank_select_register};
                     `RIU_REG_CONFIG: q_d.rdata = {31'h00000000, q_q.ext_en};
                     `RIU_REG_FSR2: q_d.rdata = {20'h00000, q_q.fsr2};
                     `RIU_REG_MADDR: q_d.rdata = {20'h00000, q_q.mem_addr};
                     `RIU_REG_MDATA: q_d.rdata = {24'h000000, mem[q_q.mem_addr]};
                     default: q_d.rdata = 32'h0000_0000;
                  endcase
               end else begin
                  unique case (avs_req.address)
                     `RIU_REG_INSTR: begin
                        wv = be_merge({16'h0000, q_q.opcode}, avs_req.writedata, avs_req.byteenable);
                        if (is_rlnc(wv[15:0]) || is_rrc(wv[15:0])) begin
                           q_d.opcode = wv[15:0];
                           q_d.state = RIU_DECODE;
                        end else begin
                           q_d.bad = 1'b1;
                        end
                     end
                     `RIU_REG_WORK: begin
                        wv = be_merge({24'h000000, q_q.w}, avs_req.writedata, avs_req.byteenable);
                        q_d.w = wv[7:0];
                     end
                     `RIU_REG_STATUS: begin
                        wv = be_merge(status_word(q_q), avs_req.writedata, avs_req.byteenable);
                        q_d.c = wv[`RIU_ST_C];
                        q_d.z = wv[`RIU_ST_Z];
                        q_d.n = wv[`RIU_ST_N];
                        q_d.bad = wv[`RIU_ST_BAD];
                     end
                     `RIU_REG_BANK: begin
                        wv = be_merge({28'h0000000, q_q.bank_select_register}, avs_req.writedata, avs_req.byteenable);
                        q_d.bank_select_register = wv[3:0];
                     end
                     `RIU_REG_CONFIG: begin
                        wv = be_merge({31'h00000000, q_q.ext_en}, avs_req.writedata, avs_req.byteenable);
                        q_d.ext_en = wv[`RIU_CFG_EXT];
                     end
                     `RIU_REG_FSR2: begin
                        wv = be_merge({20'h00000, q_q.fsr2}, avs_req.writedata, avs_req.byteenable);
                        q_d.fsr2 = wv[11:0];
                     end
                     `RIU_REG_MADDR: begin
                        wv = be_merge({20'h00000, q_q.mem_addr}, avs_req.writedata, avs_req.byteenable);
                        q_d.mem_addr = wv[11:0];
                     end
                     `RIU_REG_MDATA: begin
                        mem_we = avs_req.byteenable[0];
                        mem_wa = q_q.mem_addr;
                        mem_wd = avs_req.writedata[7:0];
                     end
                     default: begin
                        q_d.rdata = 32'h0000_0000;
                     end
                  endcase
               end
            end
         end
         RIU_DECODE: begin
            q_d.eff = calc_eff;
            q_d.state = RIU_READ;
         end
         RIU_READ: begin
            q_d.opnd = mem[q_q.eff];
            q_d.state = RIU_PROC;
         end
         RIU_PROC: begin
            if (is_rlnc(q_q.opcode)) begin
               // left by one, bit 7 wraps
               q_d.res = {q_q.opnd[6:0], q_q.opnd[7]};
            end else begin
               // right through carry, carry in at bit 7
               q_d.res = {q_q.c, q_q.opnd[7:1]};
            end
            q_d.state = RIU_PROC == q_q.state ? RIU_WRITE : RIU_IDLE;
         end
         RIU_WRITE: begin
            if (q_q.opcode[`RIU_D_BIT]) begin
               mem_we = 1'b1;
            end else begin
               q_d.w = q_q.res;
            end
            q_d.n = q_q.res[7];
            q_d.z = (q_q.res == 8'h00);
            if (is_rrc(q_q.opcode)) begin
               q_d.c = q_q.opnd[0];
            end
            q_d.state = RIU_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q_q <= RIU_RESET;
      end else begin
         q_q <= q_d;
      end
   end

   // data memory has no reset; software loads it through the window registers
   always_ff @(posedge mclk) begin
      if (mem_we && !rst) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign avs_rsp = '{readdata: q_q.rdata, waitrequest: q_q.waitreq};

   // =====================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   wire st_rlnc = is_rlnc(q_q.opcode);
   wire st_rrc = is_rrc(q_q.opcode);
   wire [7:0] f_fld = q_q.opcode[7:0];
   wire a_fld = q_q.opcode[`RIU_A_BIT];

   sequence exec_steps_s;
      q_q.state == RIU_DECODE ##1 q_q.state == RIU_READ ##1 q_q.state == RIU_PROC
         ##1 q_q.state == RIU_WRITE ##1 q_q.state == RIU_IDLE;
   endsequence

   sequence start_s;
      q_q.state == RIU_IDLE ##1 q_q.state == RIU_DECODE;
   endsequence

   exec_order_a: assert property (start_s |-> ##0 1'b1 ##0 exec_steps_s)
      else $error("execution steps out of order");
   rotl_value_a: assert property (q_q.state == RIU_READ && st_rlnc
      |=> ##1 q_q.res == {$past(q_q.opnd[6:0]), $past(q_q.opnd[7])})
      else $error("left rotate result wrong");
   rotl_nocarry_a: assert property (q_q.state == RIU_WRITE && st_rlnc |=> q_q.c == $past(q_q.c))
      else $error("left rotate touched carry");
   rotr_value_a: assert property (q_q.state == RIU_PROC && st_rrc
      |=> q_q.res[6:0] == $past(q_q.opnd[7:1]))
      else $error("right rotate result wrong");
   rotr_carry_a: assert property (q_q.state == RIU_PROC && st_rrc
      |=> q_q.res[7] == $past(q_q.c) ##1 q_q.c == $past(q_q.opnd[0], 2))
      else $error("carry not passed through");
   dest_work_a: assert property (q_q.state == RIU_WRITE && !q_q.opcode[`RIU_D_BIT]
      |=> q_q.w == $past(q_q.res) && mem[$past(q_q.eff)] == $past(mem[q_q.eff]))
      else $error("working destination wrong");
   dest_file_a: assert property (q_q.state == RIU_WRITE && q_q.opcode[`RIU_D_BIT]
      |=> mem[$past(q_q.eff)] == $past(q_q.res) && q_q.w == $past(q_q.w))
      else $error("file destination wrong");
   access_bank_a: assert property (q_q.state == RIU_READ && !a_fld && !(q_q.ext_en && f_fld <= `RIU_ILO_LIMIT)
      |-> q_q.eff == (f_fld < `RIU_ACCESS_SPLIT ? {`RIU_ACCESS_LO_BANK, f_fld} : {`RIU_ACCESS_HI_BANK, f_fld}))
      else $error("access bank address wrong");
   bank_select_a: assert property (q_q.state == RIU_READ && a_fld |-> q_q.eff == {q_q.bank_select_register, f_fld})
      else $error("banked address wrong");
   indexed_addr_a: assert property (q_q.state == RIU_READ && !a_fld && q_q.ext_en && f_fld <= `RIU_ILO_LIMIT
      |-> q_q.eff == q_q.fsr2 + {4'h0, f_fld})
      else $error("indexed address wrong");
   flags_nz_a: assert property (q_q.state == RIU_WRITE
      |=> q_q.z == ($past(q_q.res) == 8'h00) && q_q.n == $past(q_q.res[7]))
      else $error("n or z flag wrong");
endmodule

// [common/riu_params.svh]
// constants and register map of the rotate instruction unit
`ifndef RIU_PARAMS_SVH
`define RIU_PARAMS_SVH

// =====================================================
// register byte offsets
`define RIU_REG_INSTR 8'h00
`define RIU_REG_WORK 8'h04
`define RIU_REG_STATUS 8'h08
`define RIU_REG_BANK 8'h0c
`define RIU_REG_CONFIG 8'h10
`define RIU_REG_FSR2 8'h14
`define RIU_REG_MADDR 8'h18
`define RIU_REG_MDATA 8'h1c

// =====================================================
// field positions
`define RIU_ST_C 0
`define RIU_ST_Z 2
`define RIU_ST_N 4
`define RIU_ST_BAD 7
`define RIU_CFG_EXT 0
`define RIU_D_BIT 9
`define RIU_A_BIT 8

// =====================================================
// opcodes (bits 15:10) and addressing constants
`define RIU_OP_RLNC 6'h11
`define RIU_OP_RRC 6'h0c
`define RIU_ILO_LIMIT 8'h5f
`define RIU_ACCESS_SPLIT 8'h80
`define RIU_ACCESS_LO_BANK 4'h0
`define RIU_ACCESS_HI_BANK 4'hf

// =====================================================
// reset values
`define RIU_RST_WORK 8'h00
`define RIU_RST_BANK 4'h0
`define RIU_RST_FSR2 12'h000
`define RIU_RST_EXT 1'b0

`endif

// [common/riu_pkg.sv]
// types of the rotate instruction unit
package riu_pkg;

   typedef enum logic [4:0] {
      RIU_IDLE   = 5'b00001,
      RIU_DECODE = 5'b00010,
      RIU_READ   = 5'b00100,
      RIU_PROC   = 5'b01000,
      RIU_WRITE  = 5'b10000
   } riu_state_t;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } riu_avs_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } riu_avs_rsp_t;

   typedef struct packed {
      riu_state_t state;
      logic [7:0] w;
      logic n;
      logic z;
      logic c;
      logic bad;
      logic [3:0] bank_select_register;
      logic ext_en;
      logic [11:0] fsr2;
      logic [11:0] mem_addr;
      logic [15:0] opcode;
      logic [11:0] eff;
      logic [7:0] opnd;
      logic [7:0] res;
      logic waitreq;
      logic ack;
      logic [31:0] rdata;
   } riu_core_t;

endpackage

// [logic/riu_addr_calc.sv]
// effective file address of a byte-oriented operand
`timescale 1ns/1ps
`include "riu_params.svh"
module riu_addr_calc (
   input wire logic [7:0] f,      // file field of the opcode
   input wire logic a,            // access select bit
   input wire logic ext_en,       // extended set enabled
   input wire logic [3:0] bank_select_register,    // bank select register
   input wire logic [11:0] fsr2,  // index base for literal offset
   output logic [11:0] eff,       // resulting data address
   output logic indexed           // literal offset mode in use
);
   always_comb begin
      indexed = ext_en && !a && (f <= `RIU_ILO_LIMIT);
      if (indexed) begin
         eff = fsr2 + {4'h0, f};
      end else if (!a) begin
         eff = (f < `RIU_ACCESS_SPLIT) ? {`RIU_ACCESS_LO_BANK, f} : {`RIU_ACCESS_HI_BANK, f};
      end else begin
         eff = {bank_select_register, f};
      end
   end
endmodule

// [testbench/riu_rotate_unit_tb.sv]
// self-checking bench of the rotate instruction unit
`timescale 1ns/1ps
`include "riu_params.svh"
module riu_rotate_unit_tb;
   import riu_pkg::*;
   logic mclk;
   logic rst;
   riu_avs_req_t req;
   riu_avs_rsp_t rsp;
   int miscompares;
   int num_checks;
   int k;
   logic [31:0] rd;

   riu_rotate_unit DUT (
      .mclk(mclk),
      .rst(rst),
      .avs_req(req),
      .avs_rsp(rsp)
   );

   // =====================================================
   // clock and watchdog
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // about 55 cases of 11 accesses each, a few cycles per access
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      $display("watchdog expired at %0t", $time);
      tally_and_finish();
   end

   // =====================================================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // request held until the edge that samples waitrequest low
   task automatic bus(input bit wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rdat);
      int n;
      @(posedge mclk);
      req.address <= ad;
      req.read <= !wr;
      req.write <= wr;
      req.writedata <= wd;
      req.byteenable <= 4'hf;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 40);
      if (n >= 40) check(32'h1, 32'h0, "bus answer missing");
      rdat = rsp.readdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      logic [31:0] dummy;
      bus(1'b1, ad, wd, dummy);
   endtask

   task automatic run_case(input logic [5:0] op, input bit d, input bit a, input bit ext, input logic [7:0] f,
                           input logic [3:0] bank_select_register, input logic [11:0] fsr2, input logic [7:0] data,
                           input logic [7:0] w, input bit c);
      int eff;
      logic [7:0] res;
      bit cn;
      logic [31:0] r;
      if (!a && ext && f <= 8'h5f) eff = (fsr2 + f) % 4096;
      else if (!a) eff = (f < 8'h80) ? f : 12'hf00 + f;
      else eff = {bank_select_register, f};
      if (op == `RIU_OP_RLNC) begin
         res = {data[6:0], data[7]};
         cn = c;
      end else begin
         res = {c, data[7:1]};
         cn = data[0];
      end
      wr(`RIU_REG_BANK, {28'h0, bank_select_register});
      wr(`RIU_REG_CONFIG, {31'h0, ext});
      wr(`RIU_REG_FSR2, {20'h0, fsr2});
      wr(`RIU_REG_MADDR, eff[11:0]);
      wr(`RIU_REG_MDATA, {24'h0, data});
      wr(`RIU_REG_WORK, {24'h0, w});
      wr(`RIU_REG_STATUS, {31'h0, c});
      wr(`RIU_REG_INSTR, {16'h0, op, d, a, f});
      bus(1'b0, `RIU_REG_WORK, 32'h0, r);
      check(r, {24'h0, d ? w : res}, "work register");
      bus(1'b0, `RIU_REG_MDATA, 32'h0, r);
      check(r, {24'h0, d ? res : data}, "file byte");
      bus(1'b0, `RIU_REG_STATUS, 32'h0, r);
      check(r, {27'h0, res[7], 1'b0, res == 8'h00, 1'b0, cn}, "flags");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // =====================================================
   // main sequence
   initial begin
      rst = 1'b1;
      req = '0;
      miscompares = 0;
      num_checks = 0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      void'($urandom(93440));

      // reset values and an unmapped offset
      bus(1'b0, `RIU_REG_WORK, 32'h0, rd);
      check(rd, 32'h0, "work reset");
      bus(1'b0, `RIU_REG_STATUS, 32'h0, rd);
      check(rd, 32'h0, "status reset");
      bus(1'b0, `RIU_REG_BANK, 32'h0, rd);
      check(rd, 32'h0, "bank reset");
      bus(1'b0, `RIU_REG_CONFIG, 32'h0, rd);
      check(rd, 32'h0, "config reset");
      wr(8'h20, 32'h5a);
      bus(1'b0, 8'h20, 32'h0, rd);
      check(rd, 32'h0, "unmapped read");
      $display("test reset done");

      // corner values of both rotates
      run_case(`RIU_OP_RLNC, 1'b1, 1'b1, 1'b0, 8'h10, 4'h3, 12'h0, 8'h80, 8'h11, 1'b1);
      run_case(`RIU_OP_RRC, 1'b1, 1'b1, 1'b0, 8'h22, 4'h5, 12'h0, 8'h01, 8'h22, 1'b0);
      run_case(`RIU_OP_RRC, 1'b0, 1'b0, 1'b1, 8'h5f, 4'h9, 12'hfc0, 8'he6, 8'hcc, 1'b1);
      run_case(`RIU_OP_RLNC, 1'b0, 1'b0, 1'b1, 8'h60, 4'h9, 12'h300, 8'h00, 8'h33, 1'b0);
      run_case(`RIU_OP_RRC, 1'b1, 1'b0, 1'b0, 8'hf4, 4'h2, 12'h100, 8'h7f, 8'h00, 1'b1);
      $display("test corners done");

      // random mix of opcodes, destinations and address modes
      for (k = 0; k < 50; k++) begin
         run_case(($urandom % 2) ? `RIU_OP_RLNC : `RIU_OP_RRC, $urandom % 2, $urandom % 2, $urandom % 2,
                  ($urandom % 2) ? $urandom % 96 : $urandom % 256, $urandom, $urandom, $urandom,
                  $urandom, $urandom % 2);
      end
      $display("test random done");

      // other opcode is refused and flagged
      wr(`RIU_REG_WORK, 32'h5c);
      wr(`RIU_REG_INSTR, 32'h0000_0411);
      bus(1'b0, `RIU_REG_STATUS, 32'h0, rd);
      check(rd[7], 1'b1, "bad flag");
      bus(1'b0, `RIU_REG_WORK, 32'h0, rd);
      check(rd, 32'h5c, "work after bad opcode");
      wr(`RIU_REG_STATUS, 32'h0);
      bus(1'b0, `RIU_REG_STATUS, 32'h0, rd);
      check(rd, 32'h0, "bad flag cleared");
      $display("test refusal done");

      tally_and_finish();
   end
endmodule
